//--- fsrl_cmd.sv
// serial instruction handler: security register read, block/sector locks, software reset
//
// Summary of operation
// - 48h, address, eight dummy clocks, then data
// - sample on rising, drive on falling, MSB first
// - byte offset increments, wraps FFh to 00h
// - bits 15:12 pick register, 11:8 zero
// - four-byte mode takes 32-bit address
// - scheme bit picks lock bits or range
// - all lock bits set after any reset
// - 36h plus address sets one lock
// - 39h plus address clears one lock
// - 3Dh returns lock state in LSB
// - 7Eh sets every lock bit
// - 98h clears every lock bit
// - 66h then 99h; anything else disarms
// - reset aborts work, restores power-on defaults
// - 30 us recovery, all instructions rejected
// - every stacked die resets itself
`timescale 1ns/1ps
module fsrl_cmd
    import fsrl_pkg::*;
#(
    parameter int RST_CYCLES = RST_CYCLES_DFLT,
    parameter int DIE_COUNT = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic chipSelN,
    input wire logic serialClk,
    input wire logic serialInPin,
    output logic serialOut,
    output logic serialOutOeN,
    input wire logic fourByteMode,
    input wire logic protectSchemeSel,
    input wire logic protectComplement,
    input wire logic protectTopBottom,
    input wire logic [3:0] protectRangeBits,
    input wire logic [DIE_ADDR_W-1:0] protQueryAddr,
    output logic protQueryLocked,
    input wire logic secWrEn,
    input wire logic [1:0] secWrSel,
    input wire logic [7:0] secWrOffset,
    input wire logic [7:0] secWrData,
    output logic resetBusy,
    output logic [DIE_COUNT-1:0] dieResetPulse
);

    typedef struct packed {
        fsrl_state_t st;
        logic [5:0] bitCnt;
        logic [31:0] shreg;
        logic [7:0] opcode;
        logic [31:0] addr;
        logic [1:0] regSel;
        logic [7:0] offset;
        logic [7:0] txByte;
        logic lockedBit;
        logic [LOCK_COUNT-1:0] locks;
        logic armed;
        logic busy;
        logic [BUSY_W-1:0] busyCnt;
        logic sclkPrev;
        logic doBit;
        logic oeN;
        logic protOut;
        logic [DIE_COUNT-1:0] dieRst;
    } fsrl_cmd_t;

    localparam logic [BUSY_W-1:0] RST_LOAD = BUSY_W'(RST_CYCLES);
    localparam logic [BUSY_W-1:0] BUSY_LAST = BUSY_W'(1);

    fsrl_cmd_t r_ff;
    fsrl_cmd_t nxt_r;

    logic [7:0] secMem [1:3][0:SEC_BYTES-1];
    logic [2:0] pinSync;
    logic csHigh;
    logic sclkSync;
    logic dinSync;
    logic sclkRise;
    logic sclkFall;
    logic [31:0] shifted;
    logic [31:0] fullAddr;
    logic [7:0] secByte;

    // one lock bit per address: sectors in the end blocks, whole blocks between
    function automatic logic [9:0] lock_index(input logic [DIE_ADDR_W-1:0] a);
        logic [8:0] blk;
        logic [9:0] idx;
        blk = a[DIE_ADDR_W-1:BLK_LO];
        if (blk == BLK_FIRST) begin
            idx = {6'h00, a[BLK_LO-1:SEC4K_LO]};
        end else if (blk == BLK_LAST) begin
            idx = IDX_TOP_SECTORS + {6'h00, a[BLK_LO-1:SEC4K_LO]};
        end else begin
            idx = IDX_MID_BLOCKS + {1'b0, blk};
        end
        return idx;
    endfunction

    // range scheme: a power-of-two count of blocks from top or bottom
    function automatic logic range_protected(input logic [DIE_ADDR_W-1:0] a, input logic cmp, input logic tb,
                                             input logic [3:0] bp);
        logic [9:0] blk;
        logic [9:0] span;
        logic hit;
        blk = {1'b0, a[DIE_ADDR_W-1:BLK_LO]};
        span = '0;
        if (bp == 4'h0) begin
            hit = 1'b0;
        end else begin
            span = (bp > 4'ha) ? BLK_TOTAL : (10'h001 << (bp - 4'h1));
            hit = tb ? (blk < span) : (blk >= BLK_TOTAL - span);
        end
        return hit ^ cmp;
    endfunction

    function automatic logic secaddr_ok(input logic [31:0] a);
        logic [3:0] sel;
        sel = a[SEC_SEL_HI:SEC_SEL_LO];
        return (a[31:SEC_HIGH_LO] == '0) && (a[SEC_ZERO_HI:SEC_ZERO_LO] == '0)
            && (sel >= SEC_SEL_REG1) && (sel <= SEC_SEL_REG3);
    endfunction

    // serial bit counter step, shared by the opcode, address and dummy states
    function automatic logic [5:0] bit_next(input logic [5:0] c);
        return c + 6'h01;
    endfunction

    // all three pins share one latency, so data and clock edges stay aligned
    fsrl_sync #(
        .W(3)
    ) u_pin_sync (
        .clk(clk),
        .srst(srst),
        .asyncIn({chipSelN, serialClk, serialInPin}),
        .syncOut(pinSync)
    );

    assign csHigh = pinSync[2];
    assign sclkSync = pinSync[1];
    assign dinSync = pinSync[0];
    assign sclkRise = sclkSync & ~r_ff.sclkPrev;
    assign sclkFall = ~sclkSync & r_ff.sclkPrev;
    assign shifted = {r_ff.shreg[30:0], dinSync};
    // a 3-byte address leaves opcode bits in the top byte; mask them off
    assign fullAddr = fourByteMode ? shifted : {8'h00, shifted[23:0]};
    // register zero does not exist; keep the read inside the array
    assign secByte = (r_ff.regSel == 2'h0) ? 8'h00 : secMem[r_ff.regSel][r_ff.offset];

    // content is loaded by the program path outside this block
    always_ff @(posedge clk) begin
        if (secWrEn && (secWrSel != 2'h0)) begin
            secMem[secWrSel][secWrOffset] <= secWrData;
        end
    end

    always_comb begin
        nxt_r = r_ff;
        nxt_r.sclkPrev = sclkSync;
        nxt_r.dieRst = '0;

        // scheme select picks which protection source answers
        if (protectSchemeSel) begin
            nxt_r.protOut = r_ff.locks[lock_index(protQueryAddr)];
        end else begin
            nxt_r.protOut = range_protected(protQueryAddr, protectComplement, protectTopBottom, protectRangeBits);
        end

        // recovery counts down; load and busy are set together on an accepted reset
        if (r_ff.busy) begin
            nxt_r.busyCnt = r_ff.busyCnt - BUSY_LAST;
            if (r_ff.busyCnt == BUSY_LAST) begin
                nxt_r.busy = 1'b0;
            end
        end

        if (csHigh) begin
            // select high ends every frame; only a cleanly closed one takes effect
            nxt_r.oeN = 1'b1;
            nxt_r.st = FSRL_IDLE;
            if (r_ff.st == FSRL_DONE) begin
                unique case (r_ff.opcode)
                    OPC_LOCK_ONE: begin
                        nxt_r.locks[lock_index(r_ff.addr[DIE_ADDR_W-1:0])] = 1'b1;
                    end
                    OPC_UNLOCK_ONE: begin
                        nxt_r.locks[lock_index(r_ff.addr[DIE_ADDR_W-1:0])] = 1'b0;
                    end
                    OPC_LOCK_ALL: begin
                        nxt_r.locks = '1;
                    end
                    OPC_UNLOCK_ALL: begin
                        nxt_r.locks = '0;
                    end
                    OPC_RST_ENABLE: begin
                        nxt_r.armed = 1'b1;
                    end
                    OPC_RST_DEVICE: begin
                        // only reached when armed; restart lock state and hold off
                        nxt_r.locks = '1;
                        nxt_r.armed = 1'b0;
                        nxt_r.busy = 1'b1;
                        nxt_r.busyCnt = RST_LOAD;
                        nxt_r.dieRst = '1;
                    end
                    default: begin
                        nxt_r.st = FSRL_IDLE;
                    end
                endcase
            end
        end else begin
            unique case (r_ff.st)
                FSRL_IDLE: begin
                    nxt_r.st = FSRL_OPCODE;
                    nxt_r.bitCnt = '0;
                end
                FSRL_OPCODE: begin
                    // opcode bits land in the low byte of the shift register
                    if (sclkRise) begin
                        nxt_r.shreg = shifted;
                        nxt_r.bitCnt = bit_next(r_ff.bitCnt);
                        if (r_ff.bitCnt == OPC_LAST_BIT) begin
                            nxt_r.opcode = shifted[7:0];
                            nxt_r.bitCnt = '0;
                            nxt_r.armed = 1'b0;
                            if (r_ff.busy) begin
                                nxt_r.st = FSRL_IGNORE;
                            end else begin
                                unique case (shifted[7:0])
                                    OPC_SECREG_READ, OPC_LOCK_ONE, OPC_UNLOCK_ONE, OPC_LOCK_READ: begin
                                        nxt_r.st = FSRL_ADDR;
                                    end
                                    OPC_LOCK_ALL, OPC_UNLOCK_ALL, OPC_RST_ENABLE: begin
                                        nxt_r.st = FSRL_DONE;
                                    end
                                    OPC_RST_DEVICE: begin
                                        nxt_r.st = r_ff.armed ? FSRL_DONE : FSRL_IGNORE;
                                    end
                                    default: begin
                                        nxt_r.st = FSRL_IGNORE;
                                    end
                                endcase
                            end
                        end
                    end
                end
                FSRL_ADDR: begin
                    // the address length follows the mode at the last bit
                    if (sclkRise) begin
                        nxt_r.shreg = shifted;
                        nxt_r.bitCnt = bit_next(r_ff.bitCnt);
                        if (r_ff.bitCnt == (fourByteMode ? ADDR4_LAST_BIT : ADDR3_LAST_BIT)) begin
                            nxt_r.addr = fullAddr;
                            nxt_r.bitCnt = '0;
                            unique case (r_ff.opcode)
                                OPC_SECREG_READ: begin
                                    nxt_r.regSel = fullAddr[SEC_SEL_LO+1:SEC_SEL_LO];
                                    nxt_r.offset = fullAddr[7:0];
                                    nxt_r.st = secaddr_ok(fullAddr) ? FSRL_DUMMY : FSRL_IGNORE;
                                end
                                OPC_LOCK_READ: begin
                                    nxt_r.lockedBit = r_ff.locks[lock_index(fullAddr[DIE_ADDR_W-1:0])];
                                    nxt_r.st = FSRL_DATA;
                                end
                                default: begin
                                    nxt_r.st = FSRL_DONE;
                                end
                            endcase
                        end
                    end
                end
                FSRL_DUMMY: begin
                    // dummy bits are counted, their values unused
                    if (sclkRise) begin
                        nxt_r.bitCnt = bit_next(r_ff.bitCnt);
                        if (r_ff.bitCnt == DUMMY_LAST_BIT) begin
                            nxt_r.bitCnt = '0;
                            nxt_r.st = FSRL_DATA;
                        end
                    end
                end
                FSRL_DATA: begin
                    // streams until select rises; no byte count limit
                    if (sclkFall) begin
                        nxt_r.oeN = 1'b0;
                        nxt_r.bitCnt = {3'h0, r_ff.bitCnt[2:0] + 3'h1};
                        if (r_ff.bitCnt[2:0] == 3'h0) begin
                            if (r_ff.opcode == OPC_SECREG_READ) begin
                                nxt_r.doBit = secByte[7];
                                nxt_r.txByte = {secByte[6:0], 1'b0};
                            end else begin
                                nxt_r.doBit = 1'b0;
                                nxt_r.txByte = {6'h00, r_ff.lockedBit, 1'b0};
                            end
                        end else begin
                            nxt_r.doBit = r_ff.txByte[7];
                            nxt_r.txByte = {r_ff.txByte[6:0], 1'b0};
                        end
                        if (r_ff.bitCnt[2:0] == BYTE_LAST_BIT && r_ff.opcode == OPC_SECREG_READ) begin
                            nxt_r.offset = r_ff.offset + 8'h01;
                        end
                    end
                end
                FSRL_DONE: begin
                    // any clock past the last bit spoils the instruction
                    if (sclkRise) begin
                        nxt_r.st = FSRL_IGNORE;
                    end
                end
                FSRL_IGNORE: begin
                    nxt_r.st = FSRL_IGNORE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r_ff <= '0;
            r_ff.st <= FSRL_IDLE;
            r_ff.locks <= '1;
            r_ff.oeN <= 1'b1;
            // matches the synchroniser's reset level, so no edge is seen during reset
            r_ff.sclkPrev <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // every output is a register field, with no logic after the flops
    assign serialOut = r_ff.doBit;
    assign serialOutOeN = r_ff.oeN;
    assign protQueryLocked = r_ff.protOut;
    assign resetBusy = r_ff.busy;
    assign dieResetPulse = r_ff.dieRst;

endmodule

//--- fsrl_cmd_props.sv
// assertions on the ports of the lock and reset command block
`timescale 1ns/1ps
module fsrl_cmd_props
    import fsrl_pkg::*;
#(
    parameter int RST_CYCLES = RST_CYCLES_DFLT,
    parameter int DIE_COUNT = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic chipSelN,
    input wire logic serialOutOeN,
    input wire logic protectSchemeSel,
    input wire logic protectComplement,
    input wire logic [3:0] protectRangeBits,
    input wire logic protQueryLocked,
    input wire logic resetBusy,
    input wire logic [DIE_COUNT-1:0] dieResetPulse
);
    int busyLen;
    default clocking cb @(posedge clk); endclocking
    // counter instead of a long repetition, which the tools would unroll
    always_ff @(posedge clk) begin
        if (srst || !resetBusy) begin
            busyLen <= 0;
        end else begin
            busyLen <= busyLen + 1;
        end
    end
    // the answer register is cleared by reset and refills on the first free edge
    sequence s_rst_released;
        srst ##1 !srst && protectSchemeSel;
    endsequence
    sequence s_reset_fired;
        dieResetPulse != '0;
    endsequence
    property p_rst_out;
        srst |=> serialOutOeN && !resetBusy && dieResetPulse == '0;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
    property p_lock_rst;
        s_rst_released |=> protQueryLocked;
    endproperty
    a_lock_rst: assert property (p_lock_rst) else $error("lock bits not set by reset");
    property p_pulse_all;
        disable iff (srst) s_reset_fired |-> dieResetPulse == {DIE_COUNT{1'b1}};
    endproperty
    a_pulse_all: assert property (p_pulse_all) else $error("not every die got the reset");
    property p_pulse_once;
        disable iff (srst) s_reset_fired |=> dieResetPulse == '0;
    endproperty
    a_pulse_once: assert property (p_pulse_once) else $error("die reset longer than one cycle");
    property p_busy_start;
        disable iff (srst) s_reset_fired |-> ##[0:1] resetBusy;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("recovery did not start");
    property p_busy_len;
        disable iff (srst) $fell(resetBusy) && !$past(srst) |-> busyLen == RST_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("recovery span has wrong length");
    property p_busy_quiet;
        disable iff (srst) resetBusy |-> serialOutOeN;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("output driven during recovery");
    property p_deselect_quiet;
        disable iff (srst) chipSelN [*6] |-> serialOutOeN;
    endproperty
    a_deselect_quiet: assert property (p_deselect_quiet) else $error("output driven while deselected");
    property p_range_none;
        disable iff (srst) !protectSchemeSel && protectRangeBits == 4'h0 |=> protQueryLocked == $past(protectComplement);
    endproperty
    a_range_none: assert property (p_range_none) else $error("range scheme answer wrong");
endmodule

bind fsrl_cmd fsrl_cmd_props #(.RST_CYCLES(RST_CYCLES), .DIE_COUNT(DIE_COUNT)) u_props (
    .clk(clk),
    .srst(srst),
    .chipSelN(chipSelN),
    .serialOutOeN(serialOutOeN),
    .protectSchemeSel(protectSchemeSel),
    .protectComplement(protectComplement),
    .protectRangeBits(protectRangeBits),
    .protQueryLocked(protQueryLocked),
    .resetBusy(resetBusy),
    .dieResetPulse(dieResetPulse)
);

//--- fsrl_cmd_tb.sv
// self-checking bench for the lock and reset command block
`timescale 1ns/1ps
module fsrl_cmd_tb;
    import fsrl_pkg::*;
    localparam int RST_N = 800;
    logic clk = 1'b0;
    logic srst, chipSelN, serialClk, serialInPin, serialOut, serialOutOeN, fourByteMode, protectSchemeSel;
    logic protectComplement, protectTopBottom, protQueryLocked, secWrEn, resetBusy;
    logic [3:0] protectRangeBits;
    logic [DIE_ADDR_W-1:0] protQueryAddr, ad;
    logic [1:0] secWrSel, dieResetPulse;
    logic [1:0] pulseVal = 2'b00;
    logic [7:0] secWrOffset, secWrData;
    logic [7:0] d [0:3];
    int n_fail = 0;
    int n_compared = 0;
    int aBits, i, m;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (dieResetPulse !== 2'b00) pulseVal <= dieResetPulse;
    fsrl_cmd #(.RST_CYCLES(RST_N), .DIE_COUNT(2)) dut (.clk(clk), .srst(srst), .chipSelN(chipSelN),
        .serialClk(serialClk), .serialInPin(serialInPin), .serialOut(serialOut), .serialOutOeN(serialOutOeN),
        .fourByteMode(fourByteMode), .protectSchemeSel(protectSchemeSel), .protectComplement(protectComplement),
        .protectTopBottom(protectTopBottom), .protectRangeBits(protectRangeBits), .protQueryAddr(protQueryAddr),
        .protQueryLocked(protQueryLocked), .secWrEn(secWrEn), .secWrSel(secWrSel), .secWrOffset(secWrOffset),
        .secWrData(secWrData), .resetBusy(resetBusy), .dieResetPulse(dieResetPulse));
    fsrl_host_model host (.csN(chipSelN), .sclk(serialClk), .mosi(serialInPin), .miso(serialOut),
        .misoOeN(serialOutOeN));
    function automatic logic [31:0] secAddr(input logic [1:0] sel, input logic [7:0] off);
        return {16'h0, 2'b00, sel, 4'h0, off};
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            n_fail++;
        end
    endtask
    task automatic q(input logic [DIE_ADDR_W-1:0] a, input logic exp);
        @(negedge clk) protQueryAddr = a;
        repeat (2) @(negedge clk);
        chk({7'h0, protQueryLocked}, {7'h0, exp});
    endtask
    task automatic test_done;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // whole run is about 130 us of link traffic
    initial begin
        #400000;
        n_fail++;
        test_done;
    end
    initial begin
        srst = 1'b1;
        fourByteMode = 1'b0;
        protectSchemeSel = 1'b1;
        protectComplement = 1'b0;
        protectTopBottom = 1'b0;
        protectRangeBits = 4'h0;
        protQueryAddr = '0;
        secWrEn = 1'b0;
        secWrSel = 2'h1;
        secWrOffset = 8'h00;
        secWrData = 8'h00;
        void'($urandom(32'he724d7aa));
        repeat (10) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
        // block below 256 so a three-byte address still reaches it
        ad = {9'($urandom_range(254, 1)), 16'($urandom)};
        q(ad, 1'b1);
        for (m = 0; m < 2; m++) begin
            @(negedge clk) fourByteMode = m[0];
            aBits = m ? 32 : 24;
            // last two bytes and first two bytes, to cross the wrap point
            for (i = 0; i < 4; i++) begin
                d[i] = 8'($urandom);
                @(negedge clk);
                secWrEn = 1'b1;
                secWrSel = 2'(m + 2);
                secWrOffset = 8'hfe + 8'(i);
                secWrData = d[i];
            end
            @(negedge clk) secWrEn = 1'b0;
            host.frame(OPC_SECREG_READ, secAddr(2'(m + 2), 8'hfe), aBits, 8, 4);
            for (i = 0; i < 4; i++) chk(host.rdBuf[i], d[i]);
            host.frame(OPC_SECREG_READ, secAddr(2'(m + 2), 8'hfe) | 32'h0500, aBits, 8, 1);
            chk({7'h0, host.sawOe}, 8'h00);
            host.frame(OPC_UNLOCK_ALL, 0, 0, 0, 0);
            q(ad, 1'b0);
            host.frame(OPC_LOCK_ONE, 32'(ad), aBits, 0, 0);
            q(ad, 1'b1);
            q(ad + 25'h10000, 1'b0);
            host.frame(OPC_LOCK_READ, 32'(ad), aBits, 0, 2);
            chk(host.rdBuf[0], 8'h01);
            chk(host.rdBuf[1], 8'h01);
            host.frame(OPC_UNLOCK_ONE, 32'(ad), aBits, 0, 0);
            q(ad, 1'b0);
            host.frame(OPC_LOCK_READ, 32'(ad), aBits, 0, 1);
            chk(host.rdBuf[0], 8'h00);
            host.frame(OPC_LOCK_ALL, 0, 0, 0, 0);
            q(ad + 25'h10000, 1'b1);
            @(negedge clk) protectSchemeSel = 1'b0;
            q(ad, 1'b0);
            // one protected block, first at the bottom, then at the top
            @(negedge clk) protectRangeBits = 4'h1;
            protectTopBottom = 1'b1;
            q(25'h0, 1'b1);
            q(ad, 1'b0);
            @(negedge clk) protectTopBottom = 1'b0;
            q({BLK_LAST, 16'h0}, 1'b1);
            q(25'h0, 1'b0);
            @(negedge clk) protectRangeBits = 4'h0;
            @(negedge clk) protectComplement = 1'b1;
            q(ad, 1'b1);
            @(negedge clk) protectSchemeSel = 1'b1;
            protectComplement = 1'b0;
        end
        host.frame(OPC_UNLOCK_ALL, 0, 0, 0, 0);
        host.frame(OPC_RST_ENABLE, 0, 0, 0, 0);
        host.frame(OPC_LOCK_READ, 32'(ad), aBits, 0, 1);
        host.frame(OPC_RST_DEVICE, 0, 0, 0, 0);
        chk({7'h0, resetBusy}, 8'h00);
        q(ad, 1'b0);
        if (resetBusy === 1'b0) host.frame(OPC_RST_ENABLE, 0, 0, 0, 0);
        host.frame(OPC_RST_DEVICE, 0, 0, 0, 0);
        chk({7'h0, resetBusy}, 8'h01);
        chk({6'h0, pulseVal}, 8'h03);
        q(ad, 1'b1);
        host.frame(OPC_UNLOCK_ALL, 0, 0, 0, 0);
        q(ad, 1'b1);
        for (i = 0; i < 1000 && resetBusy !== 1'b0; i++) @(negedge clk);
        chk({7'h0, resetBusy}, 8'h00);
        host.frame(OPC_UNLOCK_ALL, 0, 0, 0, 0);
        q(ad, 1'b0);
        test_done;
    end
endmodule

//--- fsrl_host_model.sv
// serial host model: drives select, clock and data, captures returned bytes
`timescale 1ns/1ps
module fsrl_host_model (
    output logic csN,
    output logic sclk,
    output logic mosi,
    input wire logic miso,
    input wire logic misoOeN
);
    logic [7:0] rdBuf [0:3];
    logic sawOe = 1'b0;
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    always @(negedge misoOeN) sawOe = 1'b1;
    // data set after the falling edge, taken by the device on the rising edge
    task automatic tick(input logic b);
        mosi = b;
        #80 sclk = 1'b1;
        #80 sclk = 1'b0;
    endtask
    task automatic frame(input logic [7:0] opc, input logic [31:0] addr, input int aBits, input int nDummy,
                         input int nRd);
        int k;
        int b;
        sawOe = 1'b0;
        csN = 1'b0;
        for (k = 7; k >= 0; k--) tick(opc[k]);
        for (k = aBits - 1; k >= 0; k--) tick(addr[k]);
        for (k = 0; k < nDummy; k++) tick(~mosi);
        for (b = 0; b < nRd; b++) begin
            for (k = 7; k >= 0; k--) begin
                mosi = ~mosi;
                #80 sclk = 1'b1;
                rdBuf[b][k] = miso;
                #80 sclk = 1'b0;
            end
        end
        #80 csN = 1'b1;
        // released data line shows no stale level
        mosi = ~mosi;
        #400;
    endtask
endmodule

//--- fsrl_pkg.sv
// package: opcodes, address layout, lock map and timing for the flash lock/reset command block
package fsrl_pkg;

    // instruction codes
    localparam logic [7:0] OPC_SECREG_READ = 8'h48;
    localparam logic [7:0] OPC_LOCK_ONE = 8'h36;
    localparam logic [7:0] OPC_UNLOCK_ONE = 8'h39;
    localparam logic [7:0] OPC_LOCK_READ = 8'h3d;
    localparam logic [7:0] OPC_LOCK_ALL = 8'h7e;
    localparam logic [7:0] OPC_UNLOCK_ALL = 8'h98;
    localparam logic [7:0] OPC_RST_ENABLE = 8'h66;
    localparam logic [7:0] OPC_RST_DEVICE = 8'h99;

    // serial framing
    localparam logic [5:0] OPC_LAST_BIT = 6'h07;
    localparam logic [5:0] ADDR3_LAST_BIT = 6'h17;
    localparam logic [5:0] ADDR4_LAST_BIT = 6'h1f;
    localparam logic [5:0] DUMMY_LAST_BIT = 6'h07;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

    // security register address fields
    localparam int SEC_SEL_HI = 15;
    localparam int SEC_SEL_LO = 12;
    localparam int SEC_ZERO_HI = 11;
    localparam int SEC_ZERO_LO = 8;
    localparam int SEC_HIGH_LO = 16;
    localparam logic [3:0] SEC_SEL_REG1 = 4'h1;
    localparam logic [3:0] SEC_SEL_REG3 = 4'h3;
    localparam int SEC_BYTES = 256;

    // lock map: one die holds 512 blocks of 64 KiB; first and last block split into 16 sectors
    localparam int DIE_ADDR_W = 25;
    localparam int BLK_LO = 16;
    localparam int SEC4K_LO = 12;
    localparam logic [8:0] BLK_FIRST = 9'h000;
    localparam logic [8:0] BLK_LAST = 9'h1ff;
    localparam logic [9:0] IDX_TOP_SECTORS = 10'h010;
    localparam logic [9:0] IDX_MID_BLOCKS = 10'h01f;
    localparam int LOCK_COUNT = 542;
    localparam logic [9:0] BLK_TOTAL = 10'h200;

    // software reset recovery time
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RST_TIME_US = 30;
    localparam int RST_CYCLES_DFLT = (RST_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int BUSY_W = 16;

    typedef enum logic [2:0] {
        FSRL_IDLE,
        FSRL_OPCODE,
        FSRL_ADDR,
        FSRL_DUMMY,
        FSRL_DATA,
        FSRL_DONE,
        FSRL_IGNORE
    } fsrl_state_t;

endpackage

//--- fsrl_sync.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module fsrl_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } fsrl_sync_t;

    fsrl_sync_t r_ff;
    fsrl_sync_t nxt_r;

    // the first stage feeds only the second
    always_comb begin
        nxt_r.meta = asyncIn;
        nxt_r.stable = r_ff.meta;
    end

    // pins idle high (select inactive), so reset to ones avoids a false frame start
    always_ff @(posedge clk) begin
        if (srst) begin
            r_ff <= '1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign syncOut = r_ff.stable;

endmodule
